// ---- verilog/ifp_flash_seq.sv ----
`include "ifp_defines.svh"

// Behaviour
// - code 5Ah starts page program, C3h starts page erase, others reserved
// - core fetch and execution held while an operation runs; peripherals untouched
// - stall released on completion so the next instruction executes
// - page erase lasts 25 ms with the core stalled throughout
// - programming takes 28 us per word, linear up to 896 us
// - interrupt flags still latch; service deferred until the stall ends
// - erase sets every bit of the addressed page to one
// - flash target address is 16 bits from low and high byte registers
// - programming stops after the last word of the current page
// - ram source address is 11 bits from low byte and high bits 2:0
// - first ram byte fills bits 7:0, next byte bits 15:8, ascending
// - word count is high register bits 7:3 plus one
module ifp_flash_seq
#(
    parameter int          FIFO_DEPTH   = 16,
    parameter logic [21:0] ERASE_CYCLES = 22'(`IFP_ERASE_CYCLES),
    parameter logic [21:0] PROG_CYCLES  = 22'(`IFP_PROG_CYCLES)
)
(
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    output logic [7:0]         reg_rdata,
    output logic               cpu_stall,
    output logic               irq_defer,
    output logic               op_done,
    output logic               ram_rd,
    output logic [10:0]        ram_addr,
    input  wire logic [7:0]    ram_rdata,
    output logic               flash_wr,
    output logic               flash_erase,
    output logic [15:0]        flash_addr,
    output logic [15:0]        flash_wdata,
    input  wire logic          flash_ack_unused
);
    ifp_pkg::ifp_core_t    s_r;
    ifp_pkg::ifp_core_t    s_nxt;
    ifp_pkg::ifp_reg_req_t req;
    logic                  fifo_in_ready;
    logic                  fifo_out_valid;
    logic [15:0]           fifo_out_data;
    logic                  fifo_pop;
    logic                  tmr_load;
    logic [21:0]           tmr_value;
    logic                  tmr_busy;
    logic                  tmr_expire;
    logic [5:0]            req_words;
    logic [5:0]            page_room;
    logic [5:0]            run_words;
    logic [10:0]           ram_start;
    logic [15:0]           tgt_start;
    logic [15:0]           erase_base;
    logic                  cmd_wr;
    logic                  cmd_erase;
    logic                  cmd_prog;
    logic                  fetch_go;
    logic                  wr_last;

    assign req.wr    = reg_wr;
    assign req.rd    = reg_rd;
    assign req.addr  = reg_addr;
    assign req.wdata = reg_wdata;

    assign req_words = {1'b0, s_r.ram_hi[`IFP_LEN_MSB:`IFP_LEN_LSB]} + 6'h01;
    assign page_room = `IFP_PROG_PAGE_WORDS - {1'b0, s_r.tgt_lo[`IFP_PROG_OFS_MSB:0]};
    assign run_words = (req_words > page_room) ? page_room : req_words;

    assign ram_start  = {s_r.ram_hi[`IFP_RAM_HI_ADDR_MSB:0], s_r.ram_lo};
    assign tgt_start  = {s_r.tgt_hi, s_r.tgt_lo};
    // low byte ignored, erase lands on a page base
    assign erase_base = {s_r.tgt_hi, 8'h00};
    // command codes, acted on only while idle
    assign cmd_wr     = req.wr && (req.addr == `IFP_ADDR_CMD);
    assign cmd_erase  = cmd_wr && (req.wdata == `IFP_CMD_ERASE);
    assign cmd_prog   = cmd_wr && (req.wdata == `IFP_CMD_PROGRAM);
    assign fetch_go   = !s_r.ram_rd && !s_r.cap && !s_r.wbuf_vld && (s_r.fetch_left != 6'h00);
    assign wr_last    = (s_r.wr_left == 6'h01);

    assign cpu_stall   = (s_r.state != ifp_pkg::IFP_IDLE);
    assign irq_defer   = cpu_stall;
    assign op_done     = s_r.done;
    assign reg_rdata   = s_r.rdata;
    assign ram_rd      = s_r.ram_rd;
    assign ram_addr    = s_r.fetch_addr;
    assign flash_wr    = s_r.flash.wr;
    assign flash_erase = s_r.flash.erase;
    assign flash_addr  = s_r.flash.addr;
    assign flash_wdata = s_r.flash.data;

    // drain side pops only while no word is being timed
    assign fifo_pop = (s_r.state == ifp_pkg::IFP_PROG) && !s_r.wr_busy && !tmr_busy && fifo_out_valid
                      && (s_r.wr_left != 6'h00);

    always_comb
    begin
        s_nxt             = s_r;
        s_nxt.done        = 1'b0;
        s_nxt.ram_rd      = 1'b0;
        s_nxt.cap         = s_r.ram_rd;
        s_nxt.flash.wr    = 1'b0;
        s_nxt.flash.erase = 1'b0;
        tmr_load          = 1'b0;
        tmr_value         = PROG_CYCLES;

        // register reads answer one cycle later; command reads zero
        if (req.rd)
        begin
            unique case (req.addr)
                `IFP_ADDR_RAM_LO: s_nxt.rdata = s_r.ram_lo;
                `IFP_ADDR_RAM_HI: s_nxt.rdata = s_r.ram_hi;
                `IFP_ADDR_TGT_LO: s_nxt.rdata = s_r.tgt_lo;
                `IFP_ADDR_TGT_HI: s_nxt.rdata = s_r.tgt_hi;
                default:          s_nxt.rdata = 8'h00;
            endcase
        end

        unique case (s_r.state)
            ifp_pkg::IFP_IDLE:
            begin
                if (req.wr)
                begin
                    unique case (req.addr)
                        `IFP_ADDR_RAM_LO: s_nxt.ram_lo = req.wdata;
                        `IFP_ADDR_RAM_HI: s_nxt.ram_hi = req.wdata;
                        `IFP_ADDR_TGT_LO: s_nxt.tgt_lo = req.wdata;
                        `IFP_ADDR_TGT_HI: s_nxt.tgt_hi = req.wdata;
                        `IFP_ADDR_CMD:
                        begin
                            if (cmd_erase)
                            begin
                                s_nxt.state       = ifp_pkg::IFP_ERASE;
                                s_nxt.flash.erase = 1'b1;
                                // page base of the given address
                                s_nxt.flash.addr  = erase_base;
                                s_nxt.flash.data  = `IFP_BLANK_WORD;
                                tmr_load          = 1'b1;
                                tmr_value         = ERASE_CYCLES;
                            end
                            else if (cmd_prog)
                            begin
                                s_nxt.state      = ifp_pkg::IFP_PROG;
                                s_nxt.fetch_addr = ram_start;
                                s_nxt.fetch_left = run_words;
                                s_nxt.wr_left    = run_words;
                                s_nxt.wr_addr    = tgt_start;
                                s_nxt.have_lo    = 1'b0;
                                s_nxt.wbuf_vld   = 1'b0;
                            end
                        end
                        default:
                        begin
                        end
                    endcase
                end
            end

            ifp_pkg::IFP_ERASE:
            begin
                if (tmr_expire)
                    s_nxt.state = ifp_pkg::IFP_DONE;
            end

            ifp_pkg::IFP_PROG:
            begin
                // word leaves first, so a word finished this cycle is not lost
                if (s_r.wbuf_vld && fifo_in_ready)
                    s_nxt.wbuf_vld = 1'b0;
                // fetch side: one byte read in flight at a time
                if (s_r.cap)
                begin
                    // first byte of each pair low, second byte high
                    if (!s_r.have_lo)
                    begin
                        s_nxt.lo_byte = ram_rdata;
                        s_nxt.have_lo = 1'b1;
                    end
                    else
                    begin
                        s_nxt.wbuf     = {ram_rdata, s_r.lo_byte};
                        s_nxt.wbuf_vld = 1'b1;
                        s_nxt.have_lo  = 1'b0;
                    end
                end
                // back-pressure: no new read while a finished word waits
                if (fetch_go)
                begin
                    s_nxt.ram_rd = 1'b1;
                    if (s_r.have_lo)
                        s_nxt.fetch_left = s_r.fetch_left - 6'h01;
                end
                if (s_r.ram_rd)
                    s_nxt.fetch_addr = s_r.fetch_addr + 11'h001;

                // drain side: one word per program interval
                if (fifo_pop)
                begin
                    s_nxt.flash.wr   = 1'b1;
                    s_nxt.flash.addr = s_r.wr_addr;
                    s_nxt.flash.data = fifo_out_data;
                    s_nxt.wr_busy    = 1'b1;
                    tmr_load         = 1'b1;
                    tmr_value        = PROG_CYCLES;
                end
                if (tmr_expire)
                begin
                    s_nxt.wr_busy = 1'b0;
                    s_nxt.wr_addr = s_r.wr_addr + 16'h0001;
                    s_nxt.wr_left = s_r.wr_left - 6'h01;
                    // last word of the run ends the operation
                    if (wr_last)
                        s_nxt.state = ifp_pkg::IFP_DONE;
                end
            end

            ifp_pkg::IFP_DONE:
            begin
                s_nxt.done  = 1'b1;
                s_nxt.state = ifp_pkg::IFP_IDLE;
                // leftover fetch state must not leak into the next run
                s_nxt.fetch_left = 6'h00;
                s_nxt.wr_left    = 6'h00;
                s_nxt.wr_busy    = 1'b0;
                s_nxt.have_lo    = 1'b0;
                s_nxt.wbuf_vld   = 1'b0;
            end

            default:
                s_nxt.state = ifp_pkg::IFP_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            s_r       <= '0;
            s_r.state <= ifp_pkg::IFP_IDLE;
            s_r.rdata <= `IFP_REG_RESET;
        end
        else
            s_r <= s_nxt;
    end

    ifp_fifo
    #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    )
    u_fifo
    (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .in_valid  (s_r.wbuf_vld),
        .in_ready  (fifo_in_ready),
        .in_data   (s_r.wbuf),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    ifp_timer
    #(
        .WIDTH (22)
    )
    u_timer
    (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .load    (tmr_load),
        .value   (tmr_value),
        .busy    (tmr_busy),
        .expire  (tmr_expire)
    );
endmodule

// ---- shared/ifp_defines.svh ----
`ifndef IFP_DEFINES_SVH
`define IFP_DEFINES_SVH

// register offsets on the core's system register port
`define IFP_ADDR_RAM_LO      8'h80
`define IFP_ADDR_RAM_HI      8'h81
`define IFP_ADDR_TGT_LO      8'h83
`define IFP_ADDR_TGT_HI      8'h84
`define IFP_ADDR_CMD         8'hAF

// operation codes
`define IFP_CMD_PROGRAM      8'h5A
`define IFP_CMD_ERASE        8'hC3
`define IFP_CMD_RESET        8'h00
`define IFP_REG_RESET        8'h00

// field positions in the high ram-address register
`define IFP_RAM_HI_ADDR_MSB  2
`define IFP_LEN_MSB          7
`define IFP_LEN_LSB          3

// page geometry
`define IFP_PROG_PAGE_WORDS  6'h20
`define IFP_PROG_OFS_MSB     4
`define IFP_ERASE_PAGE_LSB   8
`define IFP_BLANK_WORD       16'hFFFF

// timing, figures as printed
`define IFP_CLK_MHZ          125
`define IFP_ERASE_TIME_MS    25
`define IFP_PROG_TIME_US     28
`define IFP_PROG_CYCLES      (`IFP_PROG_TIME_US * `IFP_CLK_MHZ)
`define IFP_ERASE_CYCLES     (`IFP_ERASE_TIME_MS * 1000 * `IFP_CLK_MHZ)

`endif

// ---- shared/ifp_pkg.sv ----
package ifp_pkg;

    typedef enum logic [3:0]
    {
        IFP_IDLE  = 4'b0001,
        IFP_ERASE = 4'b0010,
        IFP_PROG  = 4'b0100,
        IFP_DONE  = 4'b1000
    } ifp_state_t;

    // register bus request from the core
    typedef struct packed
    {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ifp_reg_req_t;

    // word handed to the flash array
    typedef struct packed
    {
        logic        wr;
        logic        erase;
        logic [15:0] addr;
        logic [15:0] data;
    } ifp_flash_req_t;

    typedef struct packed
    {
        ifp_state_t     state;
        logic [7:0]     ram_lo;
        logic [7:0]     ram_hi;
        logic [7:0]     tgt_lo;
        logic [7:0]     tgt_hi;
        logic [10:0]    fetch_addr;
        logic [5:0]     fetch_left;
        logic           ram_rd;
        logic           cap;
        logic           have_lo;
        logic [7:0]     lo_byte;
        logic [15:0]    wbuf;
        logic           wbuf_vld;
        logic [15:0]    wr_addr;
        logic [5:0]     wr_left;
        logic           wr_busy;
        ifp_flash_req_t flash;
        logic           done;
        logic [7:0]     rdata;
    } ifp_core_t;

endpackage

// ---- verilog/ifp_fifo.sv ----
module ifp_fifo
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
)
(
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed
    {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } ifp_fifo_st_t;

    ifp_fifo_st_t     s_r;
    ifp_fifo_st_t     s_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready  = (s_r.cnt != DEPTH[AW:0]);
    assign out_valid = (s_r.cnt != '0);
    assign out_data  = mem[s_r.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        s_nxt = s_r;
        if (push)
            s_nxt.wp = s_r.wp + 1'b1;
        if (pop)
            s_nxt.rp = s_r.rp + 1'b1;
        if (push && !pop)
            s_nxt.cnt = s_r.cnt + 1'b1;
        else if (pop && !push)
            s_nxt.cnt = s_r.cnt - 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            s_r <= '0;
        else
            s_r <= s_nxt;
        if (push)
            mem[s_r.wp] <= in_data;
    end
endmodule

// ---- verilog/ifp_timer.sv ----
module ifp_timer
#(
    parameter int WIDTH = 22
)
(
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] value,
    output logic                  busy,
    output logic                  expire
);
    typedef struct packed
    {
        logic [WIDTH-1:0] cnt;
        logic             busy;
        logic             expire;
    } ifp_tmr_st_t;

    ifp_tmr_st_t s_r;
    ifp_tmr_st_t s_nxt;

    assign busy   = s_r.busy;
    assign expire = s_r.expire;

    // expire pulses value + 1 cycles after the load cycle
    always_comb
    begin
        s_nxt        = s_r;
        s_nxt.expire = 1'b0;
        if (load)
        begin
            s_nxt.cnt  = value - 1'b1;
            s_nxt.busy = 1'b1;
        end
        else if (s_r.busy)
        begin
            if (s_r.cnt == '0)
            begin
                s_nxt.busy   = 1'b0;
                s_nxt.expire = 1'b1;
            end
            else
                s_nxt.cnt = s_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
endmodule

// ---- bench/ifp_mem_model.sv ----
module ifp_mem_model
(
    input  wire logic        clk_sys,
    input  wire logic        ram_rd,
    input  wire logic [10:0] ram_addr,
    output logic [7:0]       ram_rdata,
    input  wire logic        flash_wr,
    input  wire logic        flash_erase,
    input  wire logic [15:0] flash_addr,
    input  wire logic [15:0] flash_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  ram [2048];
    logic [15:0] rom [65536];
    initial
    begin
        ram_rdata = 8'h00;
        foreach (rom[i])
            rom[i] = 16'h0000;
    end
    always @(posedge clk_sys)
    begin
        // port shows a changing value when not read, inverting each cycle, so the last byte returns every other cycle
        ram_rdata <= ram_rd ? ram[ram_addr] : ~ram_rdata;
        if (flash_erase)
            for (int i = 0; i < 256; i++)
                rom[{flash_addr[15:8], i[7:0]}] <= 16'hFFFF;
        // programming can only clear bits, so an unerased word shows it
        if (flash_wr)
            rom[flash_addr] <= rom[flash_addr] & flash_wdata;
    end
endmodule

// ---- bench/ifp_flash_seq_assertions.sv ----
module ifp_flash_seq_assertions
#(
    parameter logic [21:0] ERASE_CYCLES = 22'h32,
    parameter logic [21:0] PROG_CYCLES  = 22'hA
)
(
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        cpu_stall,
    input wire logic        irq_defer,
    input wire logic        op_done,
    input wire logic        ram_rd,
    input wire logic [10:0] ram_addr,
    input wire logic        flash_wr,
    input wire logic        flash_erase,
    input wire logic [15:0] flash_addr,
    input wire logic [15:0] flash_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [21:0] since_r;
    logic        er_r;
    logic        wseen_r;
    logic        rseen_r;
    logic [15:0] last_fl_r;
    logic [10:0] last_ram_r;
    logic        cmd_w;
    logic [21:0] need_w;

    assign cmd_w  = reg_wr && reg_addr == 8'hAF && !cpu_stall;
    assign need_w = er_r ? ERASE_CYCLES : PROG_CYCLES;

    // cycles since the last flash pulse, for spacing and length
    always_ff @(posedge clk_sys)
    begin
        since_r <= (flash_wr || flash_erase) ? 22'h0 : since_r + 22'h1;
        if (flash_wr || flash_erase)
            er_r <= flash_erase;
        if (flash_wr)
            last_fl_r <= flash_addr;
        if (ram_rd)
            last_ram_r <= ram_addr;
        wseen_r <= rstn && !cmd_w && (wseen_r || flash_wr);
        rseen_r <= rstn && !cmd_w && (rseen_r || ram_rd);
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    chk_erase_start: assert property (cmd_w && reg_wdata == 8'hC3 |=> cpu_stall && flash_erase)
        else $error("no erase");
    chk_prog_start: assert property (cmd_w && reg_wdata == 8'h5A |=> cpu_stall ##[1:2] ram_rd)
        else $error("no program");
    chk_reserved_idle: assert property (cmd_w && reg_wdata != 8'h5A && reg_wdata != 8'hC3 |=> !cpu_stall)
        else $error("reserved code stalled");
    chk_idle_quiet: assert property (!cpu_stall |-> !flash_wr && !flash_erase && !ram_rd)
        else $error("flash activity while idle");
    chk_defer_same: assert property (irq_defer == cpu_stall)
        else $error("defer differs from stall");
    chk_erase_blank: assert property (flash_erase |-> flash_wdata == 16'hFFFF && flash_addr[7:0] == 8'h00)
        else $error("erase not blank");
    chk_op_length: assert property (op_done |-> since_r + 22'h1 >= need_w && since_r <= need_w + 22'h8)
        else $error("operation length");
    chk_done_release: assert property (op_done |-> $past(cpu_stall) ##1 !cpu_stall)
        else $error("stall not released");
    chk_word_order: assert property (flash_wr && wseen_r |-> flash_addr == last_fl_r + 16'h1 &&
        flash_addr[4:0] != 5'h0 && since_r + 22'h1 >= PROG_CYCLES)
        else $error("word order");
    chk_byte_order: assert property (ram_rd && rseen_r |-> ram_addr == last_ram_r + 11'h1)
        else $error("byte order");

    cov_erase: cover property (flash_erase);
    cov_page_end: cover property (flash_wr && flash_addr[4:0] == 5'h1F);
    cov_reserved: cover property (cmd_w && reg_wdata == 8'h00);
endmodule

bind ifp_flash_seq ifp_flash_seq_assertions #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) u_chk
(
    .clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .cpu_stall(cpu_stall), .irq_defer(irq_defer), .op_done(op_done), .ram_rd(ram_rd), .ram_addr(ram_addr),
    .flash_wr(flash_wr), .flash_erase(flash_erase), .flash_addr(flash_addr), .flash_wdata(flash_wdata)
);

// ---- bench/ifp_flash_seq_tb_top.sv ----
`include "ifp_defines.svh"

module ifp_flash_seq_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [21:0] ECYC = 22'h32;
    localparam logic [21:0] PCYC = 22'hA;
    localparam logic [7:0]  RSV [6] = '{8'h00, 8'hFF, 8'h5B, 8'hC2, 8'hA5, 8'h3C};
    localparam logic [7:0]  REGS [4] = '{8'h80, 8'h81, 8'h83, 8'h84};
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic        cpu_stall;
    logic        irq_defer;
    logic        op_done;
    logic        ram_rd;
    logic [10:0] ram_addr;
    logic [7:0]  ram_rdata;
    logic        flash_wr;
    logic        flash_erase;
    logic [15:0] flash_addr;
    logic [15:0] flash_wdata;
    logic [7:0]  r;
    logic [7:0]  v;
    int          err_count = 0;
    int          checks = 0;
    int          cyc = 0;
    int          stall_n = 0;
    int          ev_n = 0;
    int          done_n = 0;
    int          wdog = 0;
    int          s0, e0, d0;

    always #4 clk_sys = ~clk_sys;

    ifp_flash_seq #(.ERASE_CYCLES(ECYC), .PROG_CYCLES(PCYC)) u_ifp_flash_seq
    (
        .clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cpu_stall(cpu_stall), .irq_defer(irq_defer),
        .op_done(op_done), .ram_rd(ram_rd), .ram_addr(ram_addr), .ram_rdata(ram_rdata), .flash_wr(flash_wr),
        .flash_erase(flash_erase), .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_ack_unused(1'b0)
    );
    ifp_mem_model u_ifp_mem_model
    (
        .clk_sys(clk_sys), .ram_rd(ram_rd), .ram_addr(ram_addr), .ram_rdata(ram_rdata), .flash_wr(flash_wr),
        .flash_erase(flash_erase), .flash_addr(flash_addr), .flash_wdata(flash_wdata)
    );

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        stall_n <= stall_n + int'(cpu_stall === 1'b1);
        ev_n <= ev_n + int'(flash_wr === 1'b1) + int'(flash_erase === 1'b1);
        done_n <= done_n + int'(op_done === 1'b1);
        wdog <= wdog + 1;
        if (cyc == 60000)
        begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // strobes get an idle cycle after them, so no signal is set twice at one edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        d = reg_rdata;
        tick(1);
    endtask

    task automatic cfg(input logic [10:0] x, input logic [4:0] len, input logic [15:0] t);
        wr(`IFP_ADDR_CMD, `IFP_CMD_RESET);
        wr(`IFP_ADDR_RAM_LO, x[7:0]);
        wr(`IFP_ADDR_RAM_HI, {len, x[10:8]});
        wr(`IFP_ADDR_TGT_LO, t[7:0]);
        wr(`IFP_ADDR_TGT_HI, t[15:8]);
    endtask

    task automatic start(input logic [7:0] c);
        s0 = stall_n;
        e0 = ev_n;
        d0 = done_n;
        // clock source is the bench clock, always running
        wdog = 0; // firmware clears the watchdog
        wr(`IFP_ADDR_CMD, c);
        tick(2); // two idle cycles after the command
    endtask

    task automatic finish(input int ev, input int lo, input int hi);
        for (int i = 0; i < 4000 && cpu_stall !== 1'b0; i++)
            tick(1);
        tick(1);
        chk(cpu_stall === 1'b0 && done_n - d0 == 1, "stall not released once");
        chk(ev_n - e0 == ev, "flash pulse count");
        chk(stall_n - s0 >= lo && stall_n - s0 <= hi, "stall length");
        chk(wdog < 1000, "watchdog would overflow");
    endtask

    task automatic erase(input int p);
        logic [15:0] nxt;
        nxt = u_ifp_mem_model.rom[(p + 1) * 256];
        cfg(11'h0, 5'h0, 16'(p * 256));
        start(`IFP_CMD_ERASE);
        finish(1, ECYC, ECYC + 12);
        for (int k = 0; k < 256; k++)
            chk(u_ifp_mem_model.rom[p * 256 + k] === 16'hFFFF, "word not blank");
        chk(u_ifp_mem_model.rom[(p + 1) * 256] === nxt, "next page touched");
    endtask

    task automatic prog(input int off, input int len, input bit poke);
        int          p, b, n, x, j;
        logic [15:0] ew;
        p = 1 + $urandom_range(61); // first and last pages spared
        b = p * 256 + $urandom_range(6) * 32;
        x = $urandom_range(2047);
        n = (len + 1 < 32 - off) ? len + 1 : 32 - off;
        for (int i = 0; i < 64; i++)
            u_ifp_mem_model.ram[11'(x + i)] = 8'($urandom);
        erase(p);
        cfg(11'(x), 5'(len), 16'(b + off));
        start(`IFP_CMD_PROGRAM);
        if (poke)
        begin
            wr(`IFP_ADDR_TGT_LO, 8'(~(b + off)));
            wr(`IFP_ADDR_CMD, `IFP_CMD_ERASE);
        end
        finish(n, n * PCYC, n * (PCYC + 2) + 12);
        for (int i = 0; i <= 32; i++)
        begin
            j = 2 * (i - off);
            ew = (i >= off && i < off + n) ?
                {u_ifp_mem_model.ram[11'(x + j + 1)], u_ifp_mem_model.ram[11'(x + j)]} : 16'hFFFF;
            chk(u_ifp_mem_model.rom[b + i] === ew, "programmed word");
        end
        rd(`IFP_ADDR_TGT_LO, r);
        chk(r === 8'(b + off), "write taken while stalled");
    endtask

    initial
    begin
        void'($urandom(32'h3EF64340));
        tick(4);
        rstn = 1'b1;
        rd(`IFP_ADDR_CMD, r);
        chk(r === 8'h00, "command read");
        foreach (REGS[i])
        begin
            v = 8'($urandom);
            wr(REGS[i], v);
            rd(REGS[i], r);
            chk(r === v, "register readback");
        end
        rd(8'h85, r);
        chk(r === 8'h00, "unmapped read");
        foreach (RSV[i])
        begin
            start(RSV[i]);
            tick(3);
            chk(cpu_stall === 1'b0 && ev_n == e0 && done_n == d0, "reserved code acted");
        end
        prog(0, 31, 1'b1);
        prog(31, 31, 1'b0);
        prog(0, 0, 1'b0);
        prog(5, 31, 1'b0);
        repeat (6)
            prog($urandom_range(31), $urandom_range(31), 1'b0);
        cfg(11'h10, 5'h1F, 16'h0120);
        start(`IFP_CMD_PROGRAM);
        tick(30);
        rstn = 1'b0;
        tick(2);
        chk(cpu_stall === 1'b0 && flash_wr === 1'b0 && ram_rd === 1'b0, "outputs in reset");
        rstn = 1'b1;
        prog(3, 7, 1'b0);
        report_and_stop();
    end
endmodule
